// [core/parallel_ports.sv]
// Notes on behaviour
// - Reads: inputs give pin, outputs give latch.
// - Timer writes latch; pin follows if output.
// - Output compare owns pin; writes leave it.
// - Reset gives inputs; direction rules without timer.
// - High port: outputs, or high address expanded.
// - High read gives latch; drives in single-chip.
// - Data-bus port: I/O, or external data bus.
// - Data-bus port out of reset follows mode.
// - Data-bus latch drives only output, single-chip.
// - Open drain: zero drives low, one floats.
// - Data-bus open drain only in single-chip modes.
// - Serial port: six bits, shared with serial.
// - Serial latch reaches pin only as output.
// - Serial open drain works in every mode.
// - Low port: outputs, or low address expanded.
// - Low read always returns the latch.
// - Chip-select port: upper four carry selects when expanded.
// - Chip-select open drain works in every mode.
// - Reset: inputs float, data registers cleared.
module parallel_ports (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic [1:0] mode_strap_in,
    input port_pkg::reg_write_s reg_write_in,
    input wire logic data_bus_open_drain_in,
    input wire logic serial_open_drain_in,
    input wire logic chip_select_open_drain_in,
    input wire logic [7:0] timer_oc_en_in,
    input wire logic [7:0] timer_oc_val_in,
    input wire logic [7:0] ext_address_high_in,
    input wire logic [7:0] ext_address_low_in,
    input wire logic [7:0] ext_bus_data_in,
    input wire logic ext_bus_drive_in,
    input wire logic [5:0] serial_alt_en_in,
    input wire logic [5:0] serial_alt_val_in,
    input wire logic [5:0] serial_alt_oe_in,
    input wire logic [3:0] chip_select_en_in,
    input wire logic [3:0] chip_select_val_in,
    input wire logic [7:0] timer_pin_in,
    input wire logic [7:0] data_bus_pin_in,
    input wire logic [5:0] serial_pin_in,
    input wire logic [7:0] analog_pin_in,
    input wire logic [7:0] chip_select_pin_in,
    output port_pkg::pin8_s timer_pin_out,
    output port_pkg::pin8_s data_bus_pin_out,
    output port_pkg::pin6_s serial_pin_out,
    output port_pkg::pin8_s chip_select_pin_out,
    output logic [7:0] high_address_pin_out,
    output logic [7:0] low_address_pin_out,
    output logic [7:0] timer_port_data_out,
    output logic [7:0] timer_port_direction_out,
    output logic [7:0] high_address_port_data_out,
    output logic [7:0] data_bus_port_data_out,
    output logic [7:0] data_bus_port_direction_out,
    output logic [5:0] serial_port_data_out,
    output logic [5:0] serial_port_direction_out,
    output logic [7:0] analog_input_port_data_out,
    output logic [7:0] low_address_port_data_out,
    output logic [7:0] chip_select_port_data_out,
    output logic [7:0] chip_select_port_direction_out,
    output port_pkg::mode_e mode_out
);

    port_pkg::state_s state_q;
    port_pkg::state_s state_d;

    logic single_like;
    logic [7:0] timer_val;
    logic [7:0] timer_oe;
    logic [7:0] bus_val;
    logic [7:0] bus_oe;
    logic [5:0] serial_val;
    logic [5:0] serial_oe;
    logic [7:0] cs_val;
    logic [7:0] cs_oe;
    logic [7:0] cs_alt_en;
    logic [7:0] serial_rd_wide;

    assign single_like = port_pkg::single_chip_like(state_q.mode);
    // Selects are only offered while the external bus is in use.
    assign cs_alt_en = {chip_select_en_in & {4{~single_like}}, port_pkg::CS_FIELD_LSB_PAD};
    // The shared read-back helper is eight bits wide, so the serial port pads up and keeps the low six.
    assign serial_rd_wide = port_pkg::readback({2'h0, state_q.serial_dir}, {2'h0, state_q.serial_data},
                                               {2'h0, serial_pin_in});

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers for the bidirectional ports.

    // Output compares drive their pins, so the latch has no path out for those bits.
    port_pin_driver #(
        .WIDTH(8)
    ) u_timer_drv (
        .latch_in(state_q.timer_data),
        .dir_in(state_q.timer_dir),
        .alt_en_in(timer_oc_en_in),
        .alt_val_in(timer_oc_val_in),
        .alt_oe_in(8'hFF),
        .gp_en_in(1'b1),
        .open_drain_in(1'b0),
        .val_out(timer_val),
        .oe_out(timer_oe)
    );

    // In expanded and test modes the external bus owns every data-bus pin.
    port_pin_driver #(
        .WIDTH(8)
    ) u_bus_drv (
        .latch_in(state_q.bus_data),
        .dir_in(state_q.bus_dir),
        .alt_en_in({8{~single_like}}),
        .alt_val_in(ext_bus_data_in),
        .alt_oe_in({8{ext_bus_drive_in}}),
        .gp_en_in(single_like),
        .open_drain_in(data_bus_open_drain_in & single_like),
        .val_out(bus_val),
        .oe_out(bus_oe)
    );

    port_pin_driver #(
        .WIDTH(6)
    ) u_serial_drv (
        .latch_in(state_q.serial_data),
        .dir_in(state_q.serial_dir),
        .alt_en_in(serial_alt_en_in),
        .alt_val_in(serial_alt_val_in),
        .alt_oe_in(serial_alt_oe_in),
        .gp_en_in(1'b1),
        .open_drain_in(serial_open_drain_in),
        .val_out(serial_val),
        .oe_out(serial_oe)
    );

    port_pin_driver #(
        .WIDTH(8)
    ) u_cs_drv (
        .latch_in(state_q.cs_data),
        .dir_in(state_q.cs_dir),
        .alt_en_in(cs_alt_en),
        .alt_val_in({chip_select_val_in, port_pkg::CS_FIELD_LSB_PAD}),
        .alt_oe_in(8'hFF),
        .gp_en_in(1'b1),
        .open_drain_in(chip_select_open_drain_in),
        .val_out(cs_val),
        .oe_out(cs_oe)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        state_d = state_q;

        if (reg_write_in.wr) begin
            unique case (reg_write_in.sel)
                // The latch takes the write even while a compare owns the pin.
                port_pkg::SEL_TIMER_PORT_DATA: begin
                    state_d.timer_data = reg_write_in.data;
                end
                port_pkg::SEL_TIMER_PORT_DIRECTION: begin
                    state_d.timer_dir = reg_write_in.data;
                end
                port_pkg::SEL_HIGH_ADDRESS_PORT_DATA: begin
                    state_d.high_addr_data = reg_write_in.data;
                end
                port_pkg::SEL_DATA_BUS_PORT_DATA: begin
                    state_d.bus_data = reg_write_in.data;
                end
                port_pkg::SEL_DATA_BUS_PORT_DIRECTION: begin
                    state_d.bus_dir = reg_write_in.data;
                end
                port_pkg::SEL_SERIAL_PORT_DATA: begin
                    state_d.serial_data = reg_write_in.data[5:0];
                end
                port_pkg::SEL_SERIAL_PORT_DIRECTION: begin
                    state_d.serial_dir = reg_write_in.data[5:0];
                end
                port_pkg::SEL_LOW_ADDRESS_PORT_DATA: begin
                    state_d.low_addr_data = reg_write_in.data;
                end
                port_pkg::SEL_CHIP_SELECT_PORT_DATA: begin
                    state_d.cs_data = reg_write_in.data;
                end
                port_pkg::SEL_CHIP_SELECT_PORT_DIRECTION: begin
                    state_d.cs_dir = reg_write_in.data;
                end
                default: begin
                    state_d.cs_dir = state_q.cs_dir;
                end
            endcase
        end

        state_d.timer_pin.val = timer_val;
        state_d.timer_pin.oe = timer_oe;
        state_d.bus_pin.val = bus_val;
        state_d.bus_pin.oe = bus_oe;
        state_d.serial_pin.val = serial_val;
        state_d.serial_pin.oe = serial_oe;
        state_d.cs_pin.val = cs_val;
        state_d.cs_pin.oe = cs_oe;

        // Output-only ports drive at all times; only the source changes with mode.
        state_d.high_addr_pin = single_like ? state_q.high_addr_data : ext_address_high_in;
        state_d.low_addr_pin = single_like ? state_q.low_addr_data : ext_address_low_in;

        state_d.timer_rd = port_pkg::readback(state_q.timer_dir, state_q.timer_data, timer_pin_in);
        state_d.bus_rd = port_pkg::readback(state_q.bus_dir, state_q.bus_data, data_bus_pin_in);
        state_d.serial_rd = serial_rd_wide[5:0];
        state_d.cs_rd = port_pkg::readback(state_q.cs_dir, state_q.cs_data, chip_select_pin_in);
        // No guard against the converter's sample phase; software keeps clear of it.
        state_d.analog_rd = analog_pin_in;

        // Straps are caught while reset is held so the mode is steady on release.
        if (srst_in) begin
            state_d = '0;
            state_d.mode = port_pkg::mode_e'(mode_strap_in);
            state_d.timer_data = port_pkg::PORT8_RESET;
            state_d.timer_dir = port_pkg::PORT8_RESET;
            state_d.high_addr_data = port_pkg::PORT8_RESET;
            state_d.bus_data = port_pkg::PORT8_RESET;
            state_d.bus_dir = port_pkg::PORT8_RESET;
            state_d.serial_data = port_pkg::PORT6_RESET;
            state_d.serial_dir = port_pkg::PORT6_RESET;
            state_d.low_addr_data = port_pkg::PORT8_RESET;
            state_d.cs_data = port_pkg::PORT8_RESET;
            state_d.cs_dir = port_pkg::PORT8_RESET;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        state_q <= state_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flip-flop of the state.
    assign timer_pin_out = state_q.timer_pin;
    assign data_bus_pin_out = state_q.bus_pin;
    assign serial_pin_out = state_q.serial_pin;
    assign chip_select_pin_out = state_q.cs_pin;
    assign high_address_pin_out = state_q.high_addr_pin;
    assign low_address_pin_out = state_q.low_addr_pin;
    assign timer_port_data_out = state_q.timer_rd;
    assign timer_port_direction_out = state_q.timer_dir;
    assign high_address_port_data_out = state_q.high_addr_data;
    assign data_bus_port_data_out = state_q.bus_rd;
    assign data_bus_port_direction_out = state_q.bus_dir;
    assign serial_port_data_out = state_q.serial_rd;
    assign serial_port_direction_out = state_q.serial_dir;
    assign analog_input_port_data_out = state_q.analog_rd;
    assign low_address_port_data_out = state_q.low_addr_data;
    assign chip_select_port_data_out = state_q.cs_rd;
    assign chip_select_port_direction_out = state_q.cs_dir;
    assign mode_out = state_q.mode;

endmodule : parallel_ports

// [core/port_pin_driver.sv]
module port_pin_driver #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] latch_in,
    input wire logic [WIDTH-1:0] dir_in,
    input wire logic [WIDTH-1:0] alt_en_in,
    input wire logic [WIDTH-1:0] alt_val_in,
    input wire logic [WIDTH-1:0] alt_oe_in,
    input wire logic gp_en_in,
    input wire logic open_drain_in,
    output logic [WIDTH-1:0] val_out,
    output logic [WIDTH-1:0] oe_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // An alternate function owns its pin outright; otherwise the direction bit decides.
    always_comb begin
        logic v;
        logic e;
        v = 1'b0;
        e = 1'b0;
        val_out = '0;
        oe_out = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (alt_en_in[i]) begin
                v = alt_val_in[i];
                e = alt_oe_in[i];
            end else begin
                v = latch_in[i];
                e = gp_en_in & dir_in[i];
            end
            // Open drain keeps the low-side driver only, so a one floats the pin.
            val_out[i] = v & ~open_drain_in;
            oe_out[i] = e & ~(open_drain_in & v);
        end
    end

endmodule : port_pin_driver

// [core/port_pkg.sv]
package port_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Operating modes, captured from the mode straps while reset is held.
    typedef enum logic [1:0] {
        MODE_SINGLE_CHIP,
        MODE_EXPANDED,
        MODE_BOOTSTRAP,
        MODE_TEST
    } mode_e;

    ////////////////////////////////////////////////////////////////////////////////
    // Register select codes for the write port; other codes are ignored.
    localparam logic [3:0] SEL_TIMER_PORT_DATA = 4'h0;
    localparam logic [3:0] SEL_TIMER_PORT_DIRECTION = 4'h1;
    localparam logic [3:0] SEL_HIGH_ADDRESS_PORT_DATA = 4'h2;
    localparam logic [3:0] SEL_DATA_BUS_PORT_DATA = 4'h3;
    localparam logic [3:0] SEL_DATA_BUS_PORT_DIRECTION = 4'h4;
    localparam logic [3:0] SEL_SERIAL_PORT_DATA = 4'h5;
    localparam logic [3:0] SEL_SERIAL_PORT_DIRECTION = 4'h6;
    localparam logic [3:0] SEL_LOW_ADDRESS_PORT_DATA = 4'h7;
    localparam logic [3:0] SEL_CHIP_SELECT_PORT_DATA = 4'h8;
    localparam logic [3:0] SEL_CHIP_SELECT_PORT_DIRECTION = 4'h9;

    ////////////////////////////////////////////////////////////////////////////////
    // Values after reset, and the fill for the low four chip-select bits.
    localparam logic [7:0] PORT8_RESET = 8'h00;
    localparam logic [5:0] PORT6_RESET = 6'h00;
    localparam logic [3:0] CS_FIELD_LSB_PAD = 4'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic [7:0] val;
        logic [7:0] oe;
    } pin8_s;

    typedef struct packed {
        logic [5:0] val;
        logic [5:0] oe;
    } pin6_s;

    typedef struct packed {
        logic wr;
        logic [3:0] sel;
        logic [7:0] data;
    } reg_write_s;

    typedef struct packed {
        mode_e mode;
        logic [7:0] timer_data;
        logic [7:0] timer_dir;
        logic [7:0] high_addr_data;
        logic [7:0] bus_data;
        logic [7:0] bus_dir;
        logic [5:0] serial_data;
        logic [5:0] serial_dir;
        logic [7:0] low_addr_data;
        logic [7:0] cs_data;
        logic [7:0] cs_dir;
        pin8_s timer_pin;
        pin8_s bus_pin;
        pin6_s serial_pin;
        pin8_s cs_pin;
        logic [7:0] high_addr_pin;
        logic [7:0] low_addr_pin;
        logic [7:0] timer_rd;
        logic [7:0] bus_rd;
        logic [5:0] serial_rd;
        logic [7:0] analog_rd;
        logic [7:0] cs_rd;
    } state_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Modes in which the address and data-bus ports belong to software.
    function automatic logic single_chip_like(input mode_e m);
        single_chip_like = (m == MODE_SINGLE_CHIP) || (m == MODE_BOOTSTRAP);
    endfunction : single_chip_like

    // Output bits read back the latch, input bits the pin level.
    function automatic logic [7:0] readback(input logic [7:0] dir, input logic [7:0] latch,
                                            input logic [7:0] pin);
        readback = (dir & latch) | (~dir & pin);
    endfunction : readback

endpackage : port_pkg

// [test/pin_partner.sv]
module pin_partner (
    input port_pkg::pin8_s timer_pin_out,
    input port_pkg::pin8_s data_bus_pin_out,
    input port_pkg::pin6_s serial_pin_out,
    input port_pkg::pin8_s chip_select_pin_out,
    output logic [7:0] timer_pin_in,
    output logic [7:0] data_bus_pin_in,
    output logic [5:0] serial_pin_in,
    output logic [7:0] chip_select_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Every line has a pull-up, so a released pin reads one and a stale level never shows.
    assign timer_pin_in = (timer_pin_out.val & timer_pin_out.oe) | ~timer_pin_out.oe;
    assign data_bus_pin_in = (data_bus_pin_out.val & data_bus_pin_out.oe) | ~data_bus_pin_out.oe;
    assign serial_pin_in = (serial_pin_out.val & serial_pin_out.oe) | ~serial_pin_out.oe;
    assign chip_select_pin_in = (chip_select_pin_out.val & chip_select_pin_out.oe) | ~chip_select_pin_out.oe;
endmodule : pin_partner

// [test/port_monitor.sv]
module port_monitor (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input port_pkg::mode_e mode_out,
    input wire logic data_bus_open_drain_in,
    input wire logic serial_open_drain_in,
    input wire logic chip_select_open_drain_in,
    input wire logic [7:0] timer_oc_en_in,
    input wire logic [7:0] timer_oc_val_in,
    input wire logic [7:0] ext_address_high_in,
    input wire logic [7:0] ext_bus_data_in,
    input wire logic ext_bus_drive_in,
    input port_pkg::pin8_s timer_pin_out,
    input port_pkg::pin8_s data_bus_pin_out,
    input port_pkg::pin6_s serial_pin_out,
    input port_pkg::pin8_s chip_select_pin_out,
    input wire logic [7:0] high_address_pin_out,
    input wire logic [7:0] low_address_pin_out,
    input wire logic [7:0] timer_port_direction_out,
    input wire logic [7:0] low_address_port_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    // Pins lag their causes by one edge, so the edge right after reset is skipped.
    wire logic single_w = (mode_out == port_pkg::MODE_SINGLE_CHIP) || (mode_out == port_pkg::MODE_BOOTSTRAP);
    ////////////////////////////////////////////////////////////////////////////////
    bus_open_drain_a: assert property (!$past(srst_in) && $past(data_bus_open_drain_in) && single_w
        |-> (data_bus_pin_out.val & data_bus_pin_out.oe) == 8'h00) else $error("Bus port drove high.");
    serial_open_drain_a: assert property (!$past(srst_in) && $past(serial_open_drain_in)
        |-> (serial_pin_out.val & serial_pin_out.oe) == 6'h00) else $error("Serial port drove high.");
    cs_open_drain_a: assert property (!$past(srst_in) && $past(chip_select_open_drain_in)
        |-> (chip_select_pin_out.val & chip_select_pin_out.oe) == 8'h00) else $error("Select port drove high.");
    compare_owns_pin_a: assert property (!$past(srst_in) && ($past(timer_oc_en_in) != 8'h00)
        |-> ((timer_pin_out.oe & $past(timer_oc_en_in)) == $past(timer_oc_en_in))
        && (((timer_pin_out.val ^ $past(timer_oc_val_in)) & $past(timer_oc_en_in)) == 8'h00))
        else $error("Compare level lost.");
    timer_direction_a: assert property (!$past(srst_in) |->
        (timer_pin_out.oe & ~$past(timer_oc_en_in)) == ($past(timer_port_direction_out) & ~$past(timer_oc_en_in)))
        else $error("Timer enable wrong.");
    high_address_a: assert property (!$past(srst_in) && !single_w
        |-> high_address_pin_out == $past(ext_address_high_in)) else $error("High address wrong.");
    low_latch_pin_a: assert property (!$past(srst_in) && single_w
        |-> low_address_pin_out == $past(low_address_port_data_out)) else $error("Low latch not on pins.");
    ext_data_bus_a: assert property (!$past(srst_in) && !single_w |->
        data_bus_pin_out.oe == {8{$past(ext_bus_drive_in)}} && (!$past(ext_bus_drive_in)
        || data_bus_pin_out.val == $past(ext_bus_data_in))) else $error("Data bus wrong.");
endmodule : port_monitor

// [test/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [1:0] strap = 2'h0;
    port_pkg::reg_write_s rw = '0;
    logic od_bus = 1'b0, od_ser = 1'b0, od_cs = 1'b0, bus_drv = 1'b0;
    logic [7:0] oc_en = 8'h00, oc_val = 8'h00, a_hi = 8'h00, a_lo = 8'h00, bus_d = 8'h00, ana = 8'h00;
    logic [5:0] s_en = 6'h00, s_val = 6'h00, s_oe = 6'h00;
    logic [3:0] cs_en = 4'h0, cs_val = 4'h0;
    logic [7:0] tp_in, bp_in, cp_in, hp, lp, td, tdir, hd, bd, bdir, ad, ld, cd, cdir;
    logic [5:0] sp_in, sd, sdir;
    port_pkg::pin8_s tp, bp, cp;
    port_pkg::pin6_s sp;
    port_pkg::mode_e mode;
    int err_total = 0, n_checks = 0, cyc = 0;
    always #2.5 clk = ~clk;
    parallel_ports i_parallel_ports (.sys_clk_in(clk), .srst_in(srst), .mode_strap_in(strap), .reg_write_in(rw),
        .data_bus_open_drain_in(od_bus), .serial_open_drain_in(od_ser), .chip_select_open_drain_in(od_cs),
        .timer_oc_en_in(oc_en), .timer_oc_val_in(oc_val), .ext_address_high_in(a_hi), .ext_address_low_in(a_lo),
        .ext_bus_data_in(bus_d), .ext_bus_drive_in(bus_drv), .serial_alt_en_in(s_en), .serial_alt_val_in(s_val),
        .serial_alt_oe_in(s_oe), .chip_select_en_in(cs_en), .chip_select_val_in(cs_val), .timer_pin_in(tp_in),
        .data_bus_pin_in(bp_in), .serial_pin_in(sp_in), .analog_pin_in(ana), .chip_select_pin_in(cp_in),
        .timer_pin_out(tp), .data_bus_pin_out(bp), .serial_pin_out(sp), .chip_select_pin_out(cp),
        .high_address_pin_out(hp), .low_address_pin_out(lp), .timer_port_data_out(td),
        .timer_port_direction_out(tdir), .high_address_port_data_out(hd), .data_bus_port_data_out(bd),
        .data_bus_port_direction_out(bdir), .serial_port_data_out(sd), .serial_port_direction_out(sdir),
        .analog_input_port_data_out(ad), .low_address_port_data_out(ld), .chip_select_port_data_out(cd),
        .chip_select_port_direction_out(cdir), .mode_out(mode));
    pin_partner i_pin_partner (.timer_pin_out(tp), .data_bus_pin_out(bp), .serial_pin_out(sp),
        .chip_select_pin_out(cp), .timer_pin_in(tp_in), .data_bus_pin_in(bp_in), .serial_pin_in(sp_in),
        .chip_select_pin_in(cp_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // The ceiling is about thirty times the length of the whole sequence.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset(input logic [1:0] m);
        @(posedge clk);
        strap <= m;
        srst <= 1'b1;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
    endtask : do_reset
    task automatic wr(input logic [3:0] s, input logic [7:0] d);
        @(posedge clk);
        rw <= '{1'b1, s, d};
        @(posedge clk);
        rw.wr <= 1'b0;
    endtask : wr
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask : settle
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_single();
        do_reset(2'h0);
        settle();
        chk(tp.oe, 8'h00);
        chk(td, 8'hFF);
        chk(bp.oe, 8'h00);
        wr(port_pkg::SEL_TIMER_PORT_DIRECTION, 8'hF0);
        wr(port_pkg::SEL_TIMER_PORT_DATA, 8'hA5);
        settle();
        chk(tp.oe, 8'hF0);
        chk(tp.val & tp.oe, 8'hA0);
        chk(td, 8'hAF);
        oc_en <= 8'h30;
        oc_val <= 8'h10;
        wr(port_pkg::SEL_TIMER_PORT_DATA, 8'h00);
        settle();
        chk(tp.oe, 8'hF0);
        chk(tp.val & 8'h30, 8'h10);
        wr(port_pkg::SEL_DATA_BUS_PORT_DIRECTION, 8'hFF);
        wr(port_pkg::SEL_DATA_BUS_PORT_DATA, 8'h3C);
        wr(port_pkg::SEL_HIGH_ADDRESS_PORT_DATA, 8'h5A);
        wr(port_pkg::SEL_LOW_ADDRESS_PORT_DATA, 8'hA5);
        settle();
        chk(bp.val, 8'h3C);
        chk(bd, 8'h3C);
        chk(hp, 8'h5A);
        chk(lp, 8'hA5);
        chk(ld, 8'hA5);
        wr(port_pkg::SEL_CHIP_SELECT_PORT_DIRECTION, 8'h0F);
        wr(port_pkg::SEL_CHIP_SELECT_PORT_DATA, 8'h05);
        wr(4'hA, 8'hFF);
        settle();
        chk(cp.oe, 8'h0F);
        chk(cd, 8'hF5);
        chk(cdir, 8'h0F);
        chk(bdir, 8'hFF);
        od_bus <= 1'b1;
        od_ser <= 1'b1;
        ana <= 8'hC3;
        wr(port_pkg::SEL_SERIAL_PORT_DIRECTION, 8'h3F);
        wr(port_pkg::SEL_SERIAL_PORT_DATA, 8'h15);
        settle();
        chk(bp.oe, 8'hC3);
        chk({2'h0, sp.oe}, 8'h2A);
        chk({2'h0, sd}, 8'h15);
        chk({2'h0, sdir}, 8'h3F);
        chk(ad, 8'hC3);
    endtask : t_single
    task automatic t_expanded();
        bus_drv <= 1'b0;
        do_reset(2'h1);
        a_hi <= 8'h12;
        a_lo <= 8'h34;
        settle();
        chk(bp.oe, 8'h00);
        wr(port_pkg::SEL_HIGH_ADDRESS_PORT_DATA, 8'h77);
        bus_drv <= 1'b1;
        bus_d <= 8'h99;
        cs_en <= 4'hF;
        cs_val <= 4'hA;
        od_cs <= 1'b1;
        wr(port_pkg::SEL_SERIAL_PORT_DIRECTION, 8'h3F);
        settle();
        chk(hp, 8'h12);
        chk(hd, 8'h77);
        chk(lp, 8'h34);
        chk(bp.oe, 8'hFF);
        chk(bp.val, 8'h99);
        chk({2'h0, sp.oe}, 8'h3F);
        chk(cp.oe & 8'hF0, 8'h50);
        chk(cd, 8'hAF);
        chk({6'h00, mode}, 8'h01);
    endtask : t_expanded
    initial begin
        t_single();
        t_expanded();
        final_report();
    end
endmodule : tb

bind parallel_ports port_monitor i_port_monitor (.sys_clk_in, .srst_in, .mode_out, .data_bus_open_drain_in,
    .serial_open_drain_in, .chip_select_open_drain_in, .timer_oc_en_in, .timer_oc_val_in, .ext_address_high_in,
    .ext_bus_data_in, .ext_bus_drive_in, .timer_pin_out, .data_bus_pin_out, .serial_pin_out,
    .chip_select_pin_out, .high_address_pin_out, .low_address_pin_out, .timer_port_direction_out,
    .low_address_port_data_out);
